// ===== logic/mht_core.sv
// multi-hit time capture core with token-chain readout
// Operation
// [RULE1] fine time from 32-tap line, coarse counter
// [RULE2] reference direct, filtered, or multiplied 160/320
// [RULE3] bin 781, 195 or 98 ps
// [RULE4] hit latches line state plus coarse count
// [RULE5] per channel lead, trail, both or pair
// [RULE6] 4 hits per channel, 256-word group buffer
// [RULE7] attach channel id and add offset
// [RULE8] full channel store drops new hit
// [RULE9] continuous mode forwards all hits to FIFO
// [RULE10] trigger mode passes hits inside window
// [RULE11] 16-entry trigger FIFO of tag and event
// [RULE12] 256-word readout FIFO, limit lowers full
// [RULE13] token in starts this slave sending
// [RULE14] data ready held until get data
// [RULE15] finished slave drives token out
// [RULE16] 32k output buffer read independently
// [RULE17] global clear empties buffer, resets chips
// [RULE18] almost-full level raises interrupt
// [RULE19] full and data-ready indications
// [RULE20] error on any global error
// [RULE21] token kept or passed per mode
// [RULE22] global reset clears buffers, states, errors
// [RULE23] bunch reset loads counter offsets
// [RULE24] event reset loads event offset
// [RULE25] trigger tag is coarse count at trigger
// [RULE26] full readout FIFO stalls the transfer
//
// Implementation choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`include "mht_cfg.svh"
module mht_core #(
	parameter int NCH = `MHT_NCH,
	parameter int TAPS = `MHT_DLL_TAPS,
	parameter int CH_DEPTH = `MHT_CH_DEPTH,
	parameter int GB_DEPTH = `MHT_GB_DEPTH,
	parameter int TF_DEPTH = `MHT_TF_DEPTH,
	parameter int RF_DEPTH = `MHT_RF_DEPTH,
	parameter int OB_DEPTH = `MHT_OB_DEPTH
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// capture front end
	input wire logic [NCH-1:0] hit_i,
	input wire logic [TAPS-1:0] dll_state_i,
	input wire logic trigger_i,
	input wire logic bunch_count_reset_in_i,
	input wire logic event_count_reset_i,
	input wire logic global_clear_in_i,
	// token chain
	input wire logic token_in_i,
	input wire logic get_data_i,
	output logic token_out_o,
	output logic data_ready_o,
	output logic [31:0] data_o,
	// module status
	output logic full_o,
	output logic almost_full_irq_o,
	output logic data_flag_o,
	output logic error_o,
	output logic global_reset_o,
	output logic [1:0] ref_sel_o
);
	localparam int FW = $clog2(TAPS);
	localparam int CW = 12;
	localparam int TW = CW + FW;
	localparam int CHW = $clog2(NCH);
	localparam int SW = $clog2(CH_DEPTH);
	localparam int GW = $clog2(GB_DEPTH);
	localparam int QW = $clog2(TF_DEPTH);
	localparam int RW = $clog2(RF_DEPTH);
	localparam int OW = $clog2(OB_DEPTH);

	// ---------------------------------------------
	// helpers
	// ---------------------------------------------
	function automatic logic [FW-1:0] fine_code(input logic [TAPS-1:0] s);
		logic [FW:0] n;
		n = '0;
		for (int k = 0; k < TAPS; k++) begin
			n = n + (FW+1)'(s[k]);
		end
		return (n > (FW+1)'(TAPS-1)) ? FW'(TAPS-1) : n[FW-1:0];
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] o,
		input logic [31:0] n, input logic [3:0] s);
		logic [31:0] r;
		for (int b = 0; b < 4; b++) begin
			r[b*8+:8] = s[b] ? n[b*8+:8] : o[b*8+:8];
		end
		return r;
	endfunction

	function automatic logic [15:0] bin_ps(input logic [1:0] r);
		case (r)
			2'h2: return `MHT_BIN_160;
			2'h3: return `MHT_BIN_320;
			default: return `MHT_BIN_40;
		endcase
	endfunction

	// ---------------------------------------------
	// registers
	// ---------------------------------------------
	logic clr;
	logic [31:0] ctrl, edge_cfg, offs_lo, offs_hi, cnt_off;
	logic [CW-1:0] win, rej;
	logic [RW:0] rd_lim;
	// full 16-bit level, so a shallow buffer does not alarm out of reset
	logic [`MHT_AF_FIELD] af_level;
	logic err;
	logic acc;
	logic ob_rd;
	logic [OW:0] ob_cnt;
	logic [OW-1:0] ob_rp, ob_wp;
	logic [31:0] ob [OB_DEPTH];
	mht_pkg::mht_rd_t rd_st;
	logic mode_trig;
	assign clr = rst_i | global_clear_in_i;
	assign mode_trig = ctrl[`MHT_CTRL_TRIG];
	assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign ob_rd = acc & ~wb_we_i & (wb_adr_i == `MHT_A_OBUF) &
		(ob_cnt != '0);

	// configuration survives a global clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl <= '0;
			edge_cfg <= '0;
			offs_lo <= '0;
			offs_hi <= '0;
			cnt_off <= '0;
			win <= `MHT_WIN_RST;
			rej <= `MHT_REJ_RST;
			rd_lim <= (RW+1)'(RF_DEPTH);
			af_level <= `MHT_AF_RST;
		end else if (acc & wb_we_i) begin
			if (wb_adr_i == `MHT_A_CTRL) begin
				ctrl <= merge(ctrl, wb_dat_i, wb_sel_i);
			end else if (wb_adr_i == `MHT_A_EDGE) begin
				edge_cfg <= merge(edge_cfg, wb_dat_i, wb_sel_i);
			end else if (wb_adr_i == `MHT_A_OFFS_LO) begin
				offs_lo <= merge(offs_lo, wb_dat_i, wb_sel_i);
			end else if (wb_adr_i == `MHT_A_OFFS_HI) begin
				offs_hi <= merge(offs_hi, wb_dat_i, wb_sel_i);
			end else if (wb_adr_i == `MHT_A_CNTOFF) begin
				cnt_off <= merge(cnt_off, wb_dat_i, wb_sel_i);
			end else if (wb_adr_i == `MHT_A_WIN) begin
				win <= wb_dat_i[CW-1:0];
			end else if (wb_adr_i == `MHT_A_REJ) begin
				rej <= wb_dat_i[CW-1:0];
			end else if (wb_adr_i == `MHT_A_RDLIM) begin
				rd_lim <= wb_dat_i[RW:0]; // RULE12
			end else if (wb_adr_i == `MHT_A_AFULL) begin
				af_level <= wb_dat_i[`MHT_AF_FIELD];
			end
		end
	end

	// one-cycle answer; unmapped reads give zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= acc;
			wb_dat_o <= '0;
			if (acc & ~wb_we_i) begin
				if (wb_adr_i == `MHT_A_CTRL) begin
					wb_dat_o <= ctrl;
				end else if (wb_adr_i == `MHT_A_EDGE) begin
					wb_dat_o <= edge_cfg;
				end else if (wb_adr_i == `MHT_A_OFFS_LO) begin
					wb_dat_o <= offs_lo;
				end else if (wb_adr_i == `MHT_A_OFFS_HI) begin
					wb_dat_o <= offs_hi;
				end else if (wb_adr_i == `MHT_A_CNTOFF) begin
					wb_dat_o <= cnt_off;
				end else if (wb_adr_i == `MHT_A_WIN) begin
					wb_dat_o <= 32'(win);
				end else if (wb_adr_i == `MHT_A_REJ) begin
					wb_dat_o <= 32'(rej);
				end else if (wb_adr_i == `MHT_A_RDLIM) begin
					wb_dat_o <= 32'(rd_lim);
				end else if (wb_adr_i == `MHT_A_AFULL) begin
					wb_dat_o <= 32'(af_level);
				end else if (wb_adr_i == `MHT_A_STAT) begin
					wb_dat_o <= {bin_ps(ctrl[`MHT_CTRL_REF]), 10'h0, // RULE3
						rd_st != mht_pkg::RD_IDLE, data_flag_o,
						error_o, almost_full_irq_o, full_o, 1'b0};
				end else if (wb_adr_i == `MHT_A_OBUF) begin
					wb_dat_o <= ob_rd ? ob[ob_rp] : '0; // RULE16
				end else if (wb_adr_i == `MHT_A_OBCNT) begin
					wb_dat_o <= 32'(ob_cnt);
				end
			end
		end
	end

	// ---------------------------------------------
	// time base
	// ---------------------------------------------
	logic [CW-1:0] coarse, rej_cnt;
	logic [TW-1:0] tnow;
	assign tnow = {coarse, fine_code(dll_state_i)}; // RULE1 RULE4

	always_ff @(posedge clk_i) begin
		if (clr) begin
			coarse <= '0;
			// reject count trails by the margin, as after a bunch reset
			rej_cnt <= '0 - rej;
		end else if (bunch_count_reset_in_i) begin
			coarse <= cnt_off[`MHT_CNTOFF_COARSE]; // RULE23
			rej_cnt <= cnt_off[`MHT_CNTOFF_COARSE] - rej;
		end else begin
			coarse <= coarse + 1'b1;
			rej_cnt <= rej_cnt + 1'b1;
		end
	end

	// ---------------------------------------------
	// channel capture and store
	// ---------------------------------------------
	logic [NCH-1:0] hit_q, armed, cap_v, st_full, st_pop;
	logic [TW-1:0] lead_t [NCH];
	logic [31:0] cap_w [NCH];
	logic [31:0] st [NCH][CH_DEPTH];
	logic [SW-1:0] st_wp [NCH];
	logic [SW-1:0] st_rp [NCH];
	logic [SW:0] st_cnt [NCH];

	always_comb begin
		mht_pkg::mht_edge_t em;
		logic ld, tr;
		logic [TW-1:0] d;
		em = mht_pkg::EM_LEAD;
		ld = 1'b0;
		tr = 1'b0;
		d = '0;
		for (int i = 0; i < NCH; i++) begin
			em = mht_pkg::mht_edge_t'(edge_cfg[2*i+:2]);
			ld = hit_i[i] & ~hit_q[i];
			tr = ~hit_i[i] & hit_q[i];
			d = tnow - lead_t[i];
			cap_v[i] = 1'b0;
			cap_w[i] = {mht_pkg::WT_LEAD, 13'h0, tnow};
			case (em) // RULE5
				mht_pkg::EM_LEAD: cap_v[i] = ld;
				mht_pkg::EM_TRAIL: begin
					cap_v[i] = tr;
					cap_w[i] = {mht_pkg::WT_TRAIL, 13'h0, tnow};
				end
				mht_pkg::EM_BOTH: begin
					cap_v[i] = ld | tr;
					cap_w[i] = {tr ? mht_pkg::WT_TRAIL : mht_pkg::WT_LEAD,
						13'h0, tnow};
				end
				default: begin
					cap_v[i] = tr & armed[i];
					cap_w[i] = {mht_pkg::WT_PAIR, 5'h0, d[7:0], lead_t[i]};
				end
			endcase
			st_full[i] = st_cnt[i] == (SW+1)'(CH_DEPTH);
		end
	end

	always_ff @(posedge clk_i) begin
		if (clr) begin
			hit_q <= '0;
			armed <= '0;
			for (int i = 0; i < NCH; i++) begin
				st_wp[i] <= '0;
				st_rp[i] <= '0;
				st_cnt[i] <= '0;
				lead_t[i] <= '0;
			end
		end else begin
			hit_q <= hit_i;
			for (int i = 0; i < NCH; i++) begin
				if (hit_i[i] & ~hit_q[i]) begin
					armed[i] <= 1'b1;
					lead_t[i] <= tnow;
				end else if (~hit_i[i] & hit_q[i]) begin
					armed[i] <= 1'b0;
				end
				// a hit on a full store is dropped
				if (cap_v[i] & ~st_full[i]) begin // RULE8 RULE6
					st[i][st_wp[i]] <= cap_w[i];
					st_wp[i] <= st_wp[i] + 1'b1;
				end
				if (st_pop[i]) begin
					st_rp[i] <= st_rp[i] + 1'b1;
				end
				st_cnt[i] <= st_cnt[i] + (SW+1)'(cap_v[i] & ~st_full[i])
					- (SW+1)'(st_pop[i]);
			end
		end
	end

	// ---------------------------------------------
	// group hit buffer
	// ---------------------------------------------
	logic [31:0] gb [GB_DEPTH];
	logic [GW-1:0] gb_wp, gb_rp;
	logic [GW:0] gb_cnt;
	logic gb_full, gb_empty, mv_any, gb_pop;
	logic [CHW-1:0] mv_ch;
	logic [7:0] mv_off;
	logic [63:0] offs_all;
	assign offs_all = {offs_hi, offs_lo};
	logic [31:0] mv_w;
	assign gb_full = gb_cnt == (GW+1)'(GB_DEPTH);
	assign gb_empty = gb_cnt == '0;

	// lowest channel wins; fair enough at the store depth
	always_comb begin
		mv_any = 1'b0;
		mv_ch = '0;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (st_cnt[i] != '0) begin
				mv_any = 1'b1;
				mv_ch = CHW'(i);
			end
		end
		for (int i = 0; i < NCH; i++) begin
			st_pop[i] = mv_any & ~gb_full & (mv_ch == CHW'(i));
		end
		mv_off = offs_all[8*mv_ch+:8];
		mv_w = st[mv_ch][st_rp[mv_ch]];
		mv_w[29:27] = 3'(mv_ch); // RULE7
		mv_w[TW-1:0] = mv_w[TW-1:0] + TW'(mv_off);
	end

	always_ff @(posedge clk_i) begin
		if (clr) begin
			gb_wp <= '0;
			gb_rp <= '0;
			gb_cnt <= '0;
		end else begin
			if (mv_any & ~gb_full) begin
				gb[gb_wp] <= mv_w;
				gb_wp <= gb_wp + 1'b1;
			end
			if (gb_pop) begin
				gb_rp <= gb_rp + 1'b1;
			end
			gb_cnt <= gb_cnt + (GW+1)'(mv_any & ~gb_full)
				- (GW+1)'(gb_pop);
		end
	end

	// ---------------------------------------------
	// trigger FIFO and matching
	// ---------------------------------------------
	logic [2*CW-1:0] tf [TF_DEPTH];
	logic [QW-1:0] tf_wp, tf_rp;
	logic [QW:0] tf_cnt;
	logic [CW-1:0] evt_cnt, hc, dt, age;
	logic tf_push, tf_pop, tf_empty, rf_push, rf_full, rf_empty;
	logic [31:0] rf_w;
	assign tf_push = trigger_i & mode_trig & (tf_cnt != (QW+1)'(TF_DEPTH));
	assign tf_empty = tf_cnt == '0;
	assign hc = gb[gb_rp][TW-1:FW];
	assign dt = tf[tf_rp][2*CW-1:CW] - hc;
	assign age = rej_cnt - hc;

	always_comb begin
		gb_pop = 1'b0;
		rf_push = 1'b0;
		tf_pop = 1'b0;
		rf_w = gb[gb_rp];
		if (!rf_full) begin // RULE26
			if (!mode_trig) begin
				gb_pop = ~gb_empty; // RULE9
				rf_push = ~gb_empty;
			end else if (!tf_empty) begin
				if (!gb_empty && dt <= win) begin // RULE10
					gb_pop = 1'b1;
					rf_push = 1'b1;
				end else if (!gb_empty && dt < `MHT_HALF) begin
					gb_pop = 1'b1;
				end else begin
					rf_push = 1'b1;
					tf_pop = 1'b1;
					rf_w = {mht_pkg::WT_TRAILER, 18'h0, tf[tf_rp][CW-1:0]};
				end
			end else if (!gb_empty && age != '0 && age < `MHT_HALF) begin
				gb_pop = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (clr) begin
			tf_wp <= '0;
			tf_rp <= '0;
			tf_cnt <= '0;
			evt_cnt <= '0;
		end else begin
			if (event_count_reset_i) begin
				evt_cnt <= cnt_off[`MHT_CNTOFF_EVT]; // RULE24
			end else if (tf_push) begin
				evt_cnt <= evt_cnt + 1'b1;
			end
			if (tf_push) begin
				tf[tf_wp] <= {coarse, evt_cnt}; // RULE11 RULE25
				tf_wp <= tf_wp + 1'b1;
			end
			if (tf_pop) begin
				tf_rp <= tf_rp + 1'b1;
			end
			tf_cnt <= tf_cnt + (QW+1)'(tf_push) - (QW+1)'(tf_pop);
		end
	end

	// ---------------------------------------------
	// readout FIFO and token chain
	// ---------------------------------------------
	logic [31:0] rf [RF_DEPTH];
	logic [RW-1:0] rf_wp, rf_rp;
	logic [RW:0] rf_cnt;
	logic rf_pop;
	assign rf_full = rf_cnt >= rd_lim; // RULE12
	assign rf_empty = rf_cnt == '0;
	assign rf_pop = (rd_st == mht_pkg::RD_SEND) & get_data_i;

	always_ff @(posedge clk_i) begin
		if (clr) begin
			rf_wp <= '0;
			rf_rp <= '0;
			rf_cnt <= '0;
		end else begin
			if (rf_push) begin
				rf[rf_wp] <= rf_w;
				rf_wp <= rf_wp + 1'b1;
			end
			if (rf_pop) begin
				rf_rp <= rf_rp + 1'b1;
			end
			rf_cnt <= rf_cnt + (RW+1)'(rf_push) - (RW+1)'(rf_pop);
		end
	end

	always_ff @(posedge clk_i) begin
		if (clr) begin // RULE22
			rd_st <= mht_pkg::RD_IDLE;
			data_ready_o <= 1'b0;
			data_o <= '0;
			token_out_o <= 1'b0;
		end else begin
			token_out_o <= 1'b0;
			case (rd_st)
				mht_pkg::RD_IDLE: begin
					if (token_in_i) begin
						rd_st <= mht_pkg::RD_LOAD; // RULE13
					end
				end
				mht_pkg::RD_LOAD: begin
					if (!rf_empty) begin
						data_o <= rf[rf_rp];
						data_ready_o <= 1'b1; // RULE14
						rd_st <= mht_pkg::RD_SEND;
					end else if (!mode_trig) begin
						rd_st <= mht_pkg::RD_PASS;
					end
				end
				mht_pkg::RD_SEND: begin
					if (get_data_i) begin
						data_ready_o <= 1'b0;
						// trigger mode holds on to the end of the event
						if (mode_trig ? data_o[31:30] == mht_pkg::WT_TRAILER
							: !ctrl[`MHT_CTRL_KEEP]) begin // RULE21
							rd_st <= mht_pkg::RD_PASS;
						end else begin
							rd_st <= mht_pkg::RD_LOAD;
						end
					end
				end
				default: begin
					token_out_o <= 1'b1; // RULE15
					rd_st <= mht_pkg::RD_IDLE;
				end
			endcase
		end
	end

	// ---------------------------------------------
	// output buffer and module status
	// ---------------------------------------------
	logic ob_push;
	assign ob_push = rf_pop & (ob_cnt != (OW+1)'(OB_DEPTH));

	always_ff @(posedge clk_i) begin
		if (clr) begin // RULE17
			ob_wp <= '0;
			ob_rp <= '0;
			ob_cnt <= '0;
		end else begin
			if (ob_push) begin
				ob[ob_wp] <= data_o; // RULE16
				ob_wp <= ob_wp + 1'b1;
			end
			if (ob_rd) begin
				ob_rp <= ob_rp + 1'b1;
			end
			ob_cnt <= ob_cnt + (OW+1)'(ob_push) - (OW+1)'(ob_rd);
		end
	end

	// a dropped hit or trigger stands for the chip error
	always_ff @(posedge clk_i) begin
		if (clr) begin
			err <= 1'b0;
		end else if (|(cap_v & st_full) |
			(trigger_i & mode_trig & ~tf_push)) begin
			err <= 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			full_o <= 1'b0;
			almost_full_irq_o <= 1'b0;
			data_flag_o <= 1'b0;
			error_o <= 1'b0;
			global_reset_o <= 1'b0;
			ref_sel_o <= '0;
		end else begin
			full_o <= ob_cnt == (OW+1)'(OB_DEPTH); // RULE19
			almost_full_irq_o <= 32'(ob_cnt) >= 32'(af_level); // RULE18
			data_flag_o <= ob_cnt != '0;
			error_o <= err; // RULE20
			global_reset_o <= global_clear_in_i;
			ref_sel_o <= ctrl[`MHT_CTRL_REF]; // RULE2
		end
	end

	// ---------------------------------------------
	// assertions
	// ---------------------------------------------
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_drop;
		st_full[NCH-1] && cap_v[NCH-1] && !st_pop[NCH-1] |=>
		st_cnt[NCH-1] == $past(st_cnt[NCH-1]);
	endproperty
	a_drop: assert property (p_drop) else $error("full store took hit"); // RULE8
	property p_stall;
		rf_full && !rf_pop && !clr |=> rf_cnt == $past(rf_cnt);
	endproperty
	a_stall: assert property (p_stall) else $error("fifo grew full"); // RULE26
	property p_hold;
		data_ready_o && !get_data_i && !clr |=> data_ready_o && $stable(data_o);
	endproperty
	a_hold: assert property (p_hold) else $error("word not held"); // RULE14
	property p_pass;
		rd_st == mht_pkg::RD_PASS && !clr |=> token_out_o ##1 !token_out_o;
	endproperty
	a_pass: assert property (p_pass) else $error("token not passed"); // RULE15
	property p_start;
		rd_st == mht_pkg::RD_IDLE && token_in_i && rf_cnt > 1 &&
		!clr ##1 !clr |=> data_ready_o;
	endproperty
	a_start: assert property (p_start) else $error("no data on token"); // RULE13
	property p_clear;
		global_clear_in_i |=> ob_cnt == '0 && global_reset_o;
	endproperty
	a_clear: assert property (p_clear) else $error("clear failed"); // RULE17
	property p_af;
		32'(ob_cnt) >= 32'(af_level) && !clr |=> almost_full_irq_o;
	endproperty
	a_af: assert property (p_af) else $error("no almost full"); // RULE18
	property p_full;
		ob_cnt == (OW+1)'(OB_DEPTH) |=> full_o;
	endproperty
	a_full: assert property (p_full) else $error("no full"); // RULE19
	property p_bcr;
		bunch_count_reset_in_i && !clr |=>
		coarse == $past(cnt_off[`MHT_CNTOFF_COARSE]);
	endproperty
	a_bcr: assert property (p_bcr) else $error("coarse not loaded"); // RULE23
	property p_ecr;
		event_count_reset_i && !clr |=>
		evt_cnt == $past(cnt_off[`MHT_CNTOFF_EVT]);
	endproperty
	a_ecr: assert property (p_ecr) else $error("event not loaded"); // RULE24
	c_pair: cover property (rf_push && rf_w[31:30] == mht_pkg::WT_PAIR);
	c_trailer: cover property (tf_pop);
	c_token: cover property (token_in_i ##[1:50] token_out_o);
	c_obread: cover property (ob_rd);
endmodule

// ===== logic/mht_cfg.svh
// constants of the multi-hit time capture readout core
`ifndef MHT_CFG_SVH
`define MHT_CFG_SVH
// register byte addresses
`define MHT_A_CTRL 8'h00
`define MHT_A_EDGE 8'h04
`define MHT_A_OFFS_LO 8'h08
`define MHT_A_OFFS_HI 8'h0c
`define MHT_A_WIN 8'h10
`define MHT_A_RDLIM 8'h14
`define MHT_A_AFULL 8'h18
`define MHT_A_CNTOFF 8'h1c
`define MHT_A_REJ 8'h20
`define MHT_A_STAT 8'h24
`define MHT_A_OBUF 8'h28
`define MHT_A_OBCNT 8'h2c
// control field positions
`define MHT_CTRL_TRIG 0
`define MHT_CTRL_KEEP 1
`define MHT_CTRL_REF 3:2
`define MHT_CNTOFF_COARSE 11:0
`define MHT_CNTOFF_EVT 27:16
// structure
`define MHT_DLL_TAPS 32
`define MHT_CH_DEPTH 4
`define MHT_GB_DEPTH 256
`define MHT_TF_DEPTH 16
`define MHT_RF_DEPTH 256
`define MHT_OB_DEPTH 32768
`define MHT_NCH 8
// time bin in ps per reference choice
`define MHT_BIN_40 16'd781
`define MHT_BIN_160 16'd195
`define MHT_BIN_320 16'd98
// reset values
`define MHT_WIN_RST 12'h010
`define MHT_REJ_RST 12'h020
`define MHT_AF_RST 16'h4000
`define MHT_AF_FIELD 15:0
`define MHT_HALF 12'h800
`endif

// ===== logic/mht_pkg.sv
// types of the multi-hit time capture readout core
package mht_pkg;
	typedef enum logic [3:0] {
		RD_IDLE = 4'h1,
		RD_LOAD = 4'h2,
		RD_SEND = 4'h4,
		RD_PASS = 4'h8
	} mht_rd_t;
	typedef enum logic [1:0] {
		EM_LEAD = 2'h0,
		EM_TRAIL = 2'h1,
		EM_BOTH = 2'h2,
		EM_PAIR = 2'h3
	} mht_edge_t;
	typedef enum logic [1:0] {
		WT_LEAD = 2'h0,
		WT_TRAIL = 2'h1,
		WT_PAIR = 2'h2,
		WT_TRAILER = 2'h3
	} mht_wtype_t;
endpackage

// ===== verif/mht_master_model.sv
// readout master model driving the token chain of one slave
`timescale 1ns/1ps
module mht_master_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// bench control
	input wire logic start_i,
	input wire logic slow_i,
	// token chain
	input wire logic data_ready_i,
	input wire logic [31:0] data_i,
	input wire logic token_out_i,
	output logic token_in_o,
	output logic get_data_o,
	// results
	output logic done_o,
	output logic [31:0] word_o,
	output logic [7:0] n_words_o
);
	logic [1:0] stall;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			token_in_o <= 1'b0;
			get_data_o <= 1'b0;
			done_o <= 1'b0;
			word_o <= 32'h0;
			n_words_o <= 8'h0;
			stall <= 2'h0;
		end else begin
			token_in_o <= start_i;
			// slow mode leaves the slave waiting with its word up
			get_data_o <= data_ready_i && !get_data_o &&
				(!slow_i || stall == 2'h3);
			stall <= (data_ready_i && !get_data_o) ? stall + 2'h1 : 2'h0;
			if (get_data_o && data_ready_i) begin
				word_o <= data_i;
				n_words_o <= n_words_o + 8'h1;
			end
			if (start_i) begin
				done_o <= 1'b0;
				n_words_o <= 8'h0;
			end else if (token_out_i) begin
				done_o <= 1'b1;
			end
		end
	end
endmodule

// ===== verif/multihit_time_capture_readout_tb.sv
// self-checking bench of the time capture readout core
`timescale 1ns/1ps
`include "mht_cfg.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
	n_fail++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); \
	end end
module multihit_time_capture_readout_tb;
	typedef struct {
		logic we;
		logic [7:0] a;
		logic [31:0] d;
		logic [31:0] m;
		logic [1:0] r;
	} mht_row_t;
	localparam logic [31:0] ALL = 32'hffff_ffff;
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, trigger_i;
	logic bunch_count_reset_in_i, event_count_reset_i, global_clear_in_i;
	logic token_in_i, get_data_i, token_out_o, data_ready_o, full_o;
	logic almost_full_irq_o, data_flag_o, error_o, global_reset_o;
	logic start, slow, done;
	logic [7:0] wb_adr_i, hit_i, nw;
	logic [3:0] wb_sel_i;
	logic [1:0] ref_sel_o;
	logic [31:0] wb_dat_i, wb_dat_o, dll_state_i, data_o, word, q, w1;
	int n_fail, samples_checked;
	mht_row_t rows[17];
	// output buffer shrunk to 16 so that it fills quickly
	mht_core #(.OB_DEPTH(16)) mht_core_i (.clk_i, .rst_i, .wb_cyc_i,
		.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
		.wb_ack_o, .hit_i, .dll_state_i, .trigger_i, .bunch_count_reset_in_i,
		.event_count_reset_i, .global_clear_in_i, .token_in_i, .get_data_i,
		.token_out_o, .data_ready_o, .data_o, .full_o, .almost_full_irq_o,
		.data_flag_o, .error_o, .global_reset_o, .ref_sel_o);
	mht_master_model mht_master_model_i (.clk_i, .rst_i, .start_i(start),
		.slow_i(slow), .data_ready_i(data_ready_o), .data_i(data_o),
		.token_out_i(token_out_o), .token_in_o(token_in_i),
		.get_data_o(get_data_i), .done_o(done), .word_o(word),
		.n_words_o(nw));
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic give_verdict;
		$display("checks %0d failures %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= 4'hf;
		wb_dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (wb_ack_o !== 1'b1) n_fail++;
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		@(posedge clk_i);
	endtask
	// hands the token over and waits for it to come back
	task automatic tok(input logic s);
		int n;
		n = 0;
		slow <= s;
		start <= 1'b1;
		@(posedge clk_i);
		start <= 1'b0;
		do begin
			@(posedge clk_i);
			n++;
		end while (done !== 1'b1 && n < 400);
		if (done !== 1'b1) n_fail++;
	endtask
	task automatic clr;
		global_clear_in_i <= 1'b1;
		tick(1);
		global_clear_in_i <= 1'b0;
		tick(1);
	endtask
	initial begin
		repeat (40000) @(posedge clk_i);
		n_fail++;
		give_verdict();
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		rst_i <= 1'b1;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		wb_adr_i <= 8'h0;
		wb_sel_i <= 4'h0;
		wb_dat_i <= 32'h0;
		hit_i <= 8'h0;
		dll_state_i <= 32'h0;
		trigger_i <= 1'b0;
		bunch_count_reset_in_i <= 1'b0;
		event_count_reset_i <= 1'b0;
		global_clear_in_i <= 1'b0;
		start <= 1'b0;
		slow <= 1'b0;
		rows = '{'{1'b0, `MHT_A_CTRL, 32'h0, ALL, 2'h0},
			'{1'b0, `MHT_A_WIN, 32'h10, ALL, 2'h0},
			'{1'b0, `MHT_A_RDLIM, 32'h100, ALL, 2'h0},
			'{1'b0, `MHT_A_AFULL, 32'h4000, ALL, 2'h0},
			'{1'b0, `MHT_A_REJ, 32'h20, ALL, 2'h0},
			'{1'b0, `MHT_A_STAT, 32'h030d_0000, 32'hffff_0000, 2'h0},
			'{1'b1, 8'h30, ALL, ALL, 2'h0},
			'{1'b0, 8'h30, 32'h0, ALL, 2'h0},
			'{1'b1, `MHT_A_WIN, 32'habc, ALL, 2'h0},
			'{1'b0, `MHT_A_WIN, 32'habc, ALL, 2'h0},
			'{1'b1, `MHT_A_CTRL, 32'h4, ALL, 2'h1},
			'{1'b0, `MHT_A_STAT, 32'h030d_0000, 32'hffff_0000, 2'h1},
			'{1'b1, `MHT_A_CTRL, 32'h8, ALL, 2'h2},
			'{1'b0, `MHT_A_STAT, 32'h00c3_0000, 32'hffff_0000, 2'h2},
			'{1'b1, `MHT_A_CTRL, 32'hc, ALL, 2'h3},
			'{1'b0, `MHT_A_STAT, 32'h0062_0000, 32'hffff_0000, 2'h3},
			'{1'b1, `MHT_A_CTRL, 32'h0, ALL, 2'h0}};
		tick(3);
		`CHK({token_out_o, data_ready_o, wb_ack_o, error_o}, 4'h0);
		rst_i <= 1'b0;
		tick(1);
		foreach (rows[i]) begin
			wb(rows[i].we, rows[i].a, rows[i].d);
			if (!rows[i].we) `CHK(q & rows[i].m, rows[i].d);
			tick(1);
			`CHK(ref_sel_o, rows[i].r);
		end
		// two leading edges on channel 2, six cycles apart
		wb(1'b1, `MHT_A_OFFS_LO, 32'h0005_0000);
		wb(1'b1, `MHT_A_CNTOFF, 32'h0000_0100);
		dll_state_i <= 32'h0000_00ff;
		bunch_count_reset_in_i <= 1'b1;
		tick(1);
		bunch_count_reset_in_i <= 1'b0;
		hit_i <= 8'h04;
		tick(2);
		hit_i <= 8'h00;
		tick(4);
		hit_i <= 8'h04;
		tick(2);
		hit_i <= 8'h00;
		tick(10);
		tok(1'b0);
		`CHK(nw, 8'd1);
		w1 = word;
		`CHK(w1[31:27], 5'h02);
		`CHK(w1[4:0], 5'd13);
		`CHK(w1[16:5] - 12'h100 < 12'h8, 1'b1);
		tok(1'b1);
		`CHK(nw, 8'd1);
		`CHK(word[16:5] - w1[16:5], 12'h006);
		tok(1'b0);
		`CHK(nw, 8'd0);
		wb(1'b0, `MHT_A_OBCNT, 32'h0);
		`CHK(q, 32'h2);
		`CHK(data_flag_o, 1'b1);
		wb(1'b0, `MHT_A_OBUF, 32'h0);
		`CHK(q, w1);
		// channel 2 paired: lead time plus width of five periods
		wb(1'b1, `MHT_A_EDGE, 32'h30);
		hit_i <= 8'h04;
		tick(5);
		hit_i <= 8'h00;
		tick(10);
		tok(1'b0);
		`CHK({word[31:30], word[24:17]},
			{mht_pkg::WT_PAIR, 8'(5 * `MHT_DLL_TAPS)});
		// token kept until empty; output buffer overfills
		clr;
		`CHK(global_reset_o, 1'b1);
		tick(1);
		wb(1'b0, `MHT_A_OBCNT, 32'h0);
		`CHK({q, data_flag_o}, 33'h0);
		wb(1'b1, `MHT_A_CTRL, 32'h2);
		wb(1'b1, `MHT_A_AFULL, 32'h4);
		repeat (18) begin
			hit_i <= 8'h01;
			tick(1);
			hit_i <= 8'h00;
			tick(1);
		end
		tick(10);
		tok(1'b1);
		`CHK(nw, 8'd18);
		`CHK({full_o, almost_full_irq_o}, 2'h3);
		wb(1'b0, `MHT_A_OBCNT, 32'h0);
		`CHK(q, 32'h10);
		// trigger matching: one hit inside the window, then trailer
		clr;
		wb(1'b1, `MHT_A_CTRL, 32'h1);
		wb(1'b1, `MHT_A_WIN, 32'h10);
		wb(1'b1, `MHT_A_CNTOFF, 32'h00a5_0000);
		event_count_reset_i <= 1'b1;
		tick(1);
		event_count_reset_i <= 1'b0;
		hit_i <= 8'h02;
		tick(1);
		hit_i <= 8'h00;
		tick(3);
		trigger_i <= 1'b1;
		tick(1);
		trigger_i <= 1'b0;
		tick(10);
		tok(1'b0);
		`CHK(nw, 8'd2);
		`CHK({word[31:30], word[11:0]}, 14'h30a5);
		wb(1'b0, `MHT_A_OBUF, 32'h0);
		`CHK(q[31:27], 5'h01);
		// readout fifo limited to one word; triggers pile up
		wb(1'b1, `MHT_A_RDLIM, 32'h1);
		trigger_i <= 1'b1;
		tick(24);
		trigger_i <= 1'b0;
		tick(2);
		`CHK(error_o, 1'b1);
		clr;
		tick(1);
		`CHK(error_o, 1'b0);
		// all channels on both edges; all but channel 0 starve and overflow
		wb(1'b1, `MHT_A_EDGE, 32'haaaa);
		repeat (8) begin
			hit_i <= ~hit_i;
			tick(1);
		end
		tick(2);
		`CHK(error_o, 1'b1);
		give_verdict();
	end
endmodule
